// ===== clk_gate_ctrl.sv
/*
 * Peripheral clock gating control: run, sleep and deep-sleep gating sets,
 * bus-fault flags for unclocked units, deep-sleep oscillator choice with
 * restore on wake, clock-check fault substitution and clear, and the
 * regulator-fault reset option, all behind an AHB-Lite slave.
 * Assumes one 20 MHz clock, single word transfers, and that the power
 * requests and wake event come from logic on the same clock.
 */
// Local design decision: the AHB-Lite slave port.
// Function
// RULE_01 Gate bit one clocks the peripheral.
// RULE_02 Access to unclocked unit gives bus fault.
// RULE_03 All gating bits reset to zero.
// RULE_04 Run, sleep, deep-sleep sets, 0x10 apart.
// RULE_05 Sleep sets apply only with auto gating.
// RULE_06 Set1: comparator bit 24, timers 18-16.
// RULE_07 Set1: I2C 12, sync serial 4, async 1-0.
// RULE_08 Set2: GPIO A-E bits 0-4, rest reserved.
// RULE_09 Reserved bits kept; software preserves them. The code masks them off on write, so they read zero.
// RULE_10 Oscillator select: internal clock in deep sleep.
// RULE_11 Select clear: main oscillator stays in deep sleep.
// RULE_12 Wake restores clock source from deep-sleep onset.
// RULE_13 Fault present: substitute a known good clock.
// RULE_14 Clear bit clears faults; not self-clearing.
// RULE_15 Enable bit lets unregulated regulator reset part.
// RULE_16 Active set chosen from current power state.
`timescale 1ns/1ps
`default_nettype none
module clk_gate_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic wake_event,
  input wire clk_gate_pkg::gate_vec_t periph_access,
  output clk_gate_pkg::gate_vec_t periph_clk_en,
  output clk_gate_pkg::gate_vec_t periph_bus_fault,
  output logic [1:0] power_state,
  output logic sysclk_internal_sel,
  output logic main_osc_pwrdn,
  output logic internal_osc_pwrup,
  input wire logic clk_check_fault,
  output logic backup_clk_sel,
  input wire logic regulator_unregulated,
  output logic part_reset_req
);

  // ****************************************************************
  // State of the block.
  // ****************************************************************
  typedef struct packed {
    logic [31:0] run1;
    logic [31:0] run2;
    logic [31:0] slp1;
    logic [31:0] slp2;
    logic [31:0] dsl1;
    logic [31:0] dsl2;
    logic internal_osc_select;
    logic verify_fault_clear_bit;
    logic regulator_fault_reset_enable;
    logic auto_gating_select;
    clk_gate_pkg::pwr_state_t pstate;
    logic [2:0] fault_sync;
    logic fault_level;
    logic fault_active;
    logic [2:0] ldo_sync;
    logic ldo_level;
    logic part_reset;
    logic sel_internal;
    logic saved_sel;
    logic main_off;
    clk_gate_pkg::gate_vec_t clk_en;
    logic dp_wr;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Maps the two gating words of one set onto the gate vector.
  function automatic clk_gate_pkg::gate_vec_t map_gates(input logic [31:0] s1,
                                                        input logic [31:0] s2);
    clk_gate_pkg::gate_vec_t g;
    g.comparator0_gate = s1[clk_gate_pkg::COMPARATOR0_BIT]; // RULE_06
    g.timer2_gate = s1[clk_gate_pkg::TIMER2_BIT];
    g.timer1_gate = s1[clk_gate_pkg::TIMER1_BIT];
    g.timer0_gate = s1[clk_gate_pkg::TIMER0_BIT];
    g.i2c_gate = s1[clk_gate_pkg::I2C_BIT]; // RULE_07
    g.sync_serial_gate = s1[clk_gate_pkg::SYNC_SERIAL_BIT];
    g.async_serial1_gate = s1[clk_gate_pkg::ASYNC_SERIAL1_BIT];
    g.async_serial0_gate = s1[clk_gate_pkg::ASYNC_SERIAL0_BIT];
    g.gpio_gate = s2[clk_gate_pkg::GPIO_LAST_BIT:0]; // RULE_08
    return g;
  endfunction

  // Picks the gating set that the power state calls for.
  function automatic clk_gate_pkg::gate_vec_t active_gates(input state_t s);
    clk_gate_pkg::gate_vec_t g;
    g = map_gates(s.run1, s.run2); // RULE_16
    if (s.auto_gating_select) begin // RULE_05
      if (s.pstate == clk_gate_pkg::PWR_SLEEP) begin
        g = map_gates(s.slp1, s.slp2);
      end else if (s.pstate == clk_gate_pkg::PWR_DEEP) begin
        g = map_gates(s.dsl1, s.dsl2);
      end
    end
    return g;
  endfunction

  // Returns the read value at a byte offset; unmapped offsets read zero.
  function automatic logic [31:0] read_reg(input state_t s, input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      clk_gate_pkg::RUN_GATING_SET1_OFS: d = s.run1;
      clk_gate_pkg::RUN_GATING_SET2_OFS: d = s.run2;
      clk_gate_pkg::SLEEP_GATING_SET1_OFS: d = s.slp1;
      clk_gate_pkg::SLEEP_GATING_SET2_OFS: d = s.slp2;
      clk_gate_pkg::DEEP_SLEEP_GATING_SET1_OFS: d = s.dsl1;
      clk_gate_pkg::DEEP_SLEEP_GATING_SET2_OFS: d = s.dsl2;
      clk_gate_pkg::DEEP_SLEEP_CLOCK_SELECT_OFS: d[0] = s.internal_osc_select;
      clk_gate_pkg::CLOCK_CHECK_FAULT_CLEAR_OFS: d[0] = s.verify_fault_clear_bit;
      clk_gate_pkg::REGULATOR_FAULT_RESET_CTL_OFS: d[0] = s.regulator_fault_reset_enable;
      clk_gate_pkg::GATING_MODE_CTL_OFS: begin
        d[0] = s.auto_gating_select;
        d[1] = s.fault_active;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  logic addr_phase;
  logic fault_event;
  logic [31:0] wd;

  // Computes the whole next state from the present state and the inputs.
  always_comb begin
    state_next = state_reg;
    addr_phase = hsel && htrans[1] && hready;
    wd = hwdata;
    // Bus address phase: remember a write, capture read data early.
    state_next.dp_wr = addr_phase && hwrite;
    state_next.dp_addr = haddr[11:0];
    if (addr_phase && !hwrite) begin
      state_next.rdata = read_reg(state_reg, haddr[11:0]);
    end
    // Bus data phase: reserved bits are masked off and read as zero.
    if (state_reg.dp_wr) begin
      case (state_reg.dp_addr) // RULE_04
        clk_gate_pkg::RUN_GATING_SET1_OFS: state_next.run1 = wd & clk_gate_pkg::SET1_MASK; // RULE_09
        clk_gate_pkg::RUN_GATING_SET2_OFS: state_next.run2 = wd & clk_gate_pkg::SET2_MASK;
        clk_gate_pkg::SLEEP_GATING_SET1_OFS: state_next.slp1 = wd & clk_gate_pkg::SET1_MASK;
        clk_gate_pkg::SLEEP_GATING_SET2_OFS: state_next.slp2 = wd & clk_gate_pkg::SET2_MASK;
        clk_gate_pkg::DEEP_SLEEP_GATING_SET1_OFS: state_next.dsl1 = wd & clk_gate_pkg::SET1_MASK;
        clk_gate_pkg::DEEP_SLEEP_GATING_SET2_OFS: state_next.dsl2 = wd & clk_gate_pkg::SET2_MASK;
        clk_gate_pkg::DEEP_SLEEP_CLOCK_SELECT_OFS: state_next.internal_osc_select = wd[0];
        clk_gate_pkg::CLOCK_CHECK_FAULT_CLEAR_OFS: state_next.verify_fault_clear_bit = wd[0];
        clk_gate_pkg::REGULATOR_FAULT_RESET_CTL_OFS: state_next.regulator_fault_reset_enable = wd[0];
        clk_gate_pkg::GATING_MODE_CTL_OFS: state_next.auto_gating_select = wd[0];
        default: state_next.dp_wr = state_next.dp_wr;
      endcase
    end
    // Power state machine; deep sleep wins over sleep when both are asked.
    case (state_reg.pstate)
      clk_gate_pkg::PWR_RUN: begin
        if (deep_sleep_req) begin
          state_next.pstate = clk_gate_pkg::PWR_DEEP;
          state_next.saved_sel = state_reg.sel_internal;
          if (state_reg.internal_osc_select) begin // RULE_10
            state_next.sel_internal = 1'b1;
            state_next.main_off = 1'b1;
          end
        end else if (sleep_req) begin
          state_next.pstate = clk_gate_pkg::PWR_SLEEP;
        end
      end
      clk_gate_pkg::PWR_SLEEP: begin
        if (wake_event) begin
          state_next.pstate = clk_gate_pkg::PWR_RUN;
        end
      end
      clk_gate_pkg::PWR_DEEP: begin
        if (wake_event) begin
          state_next.pstate = clk_gate_pkg::PWR_RUN;
          state_next.sel_internal = state_reg.saved_sel; // RULE_12
          state_next.main_off = 1'b0; // RULE_11
        end
      end
      default: state_next.pstate = clk_gate_pkg::PWR_RUN;
    endcase
    // Clock-check fault: three-stage synchroniser, change taken when the last two stages agree.
    state_next.fault_sync = {state_reg.fault_sync[1:0], clk_check_fault};
    if (state_reg.fault_sync[1] == state_reg.fault_sync[2]) begin
      state_next.fault_level = state_reg.fault_sync[2];
    end
    fault_event = state_next.fault_level && !state_reg.fault_level;
    // A new fault wins over a clear held in the same cycle.
    state_next.fault_active = fault_event ||
      (state_reg.fault_active && !state_reg.verify_fault_clear_bit); // RULE_14
    // Regulator status: same synchroniser, reset request gated by enable.
    state_next.ldo_sync = {state_reg.ldo_sync[1:0], regulator_unregulated};
    if (state_reg.ldo_sync[1] == state_reg.ldo_sync[2]) begin
      state_next.ldo_level = state_reg.ldo_sync[2];
    end
    state_next.part_reset = state_reg.regulator_fault_reset_enable &&
      state_reg.ldo_level; // RULE_15
    // Clock enables follow the active set of the next state.
    state_next.clk_en = active_gates(state_next); // RULE_01
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Registers the state; every gating bit and control bit resets to zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0; // RULE_03
      state_reg.run1 <= clk_gate_pkg::GATING_RESET;
      state_reg.pstate <= clk_gate_pkg::PWR_RUN;
      state_reg.internal_osc_select <= clk_gate_pkg::CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************

  // Zero-wait slave that always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  // Unit clocks, bus-fault flags and clock source controls.
  assign periph_clk_en = state_reg.clk_en;
  assign periph_bus_fault = periph_access & ~state_reg.clk_en; // RULE_02
  assign power_state = state_reg.pstate;
  assign sysclk_internal_sel = state_reg.sel_internal;
  assign main_osc_pwrdn = state_reg.main_off;
  assign internal_osc_pwrup = state_reg.sel_internal;
  assign backup_clk_sel = state_reg.fault_active; // RULE_13
  assign part_reset_req = state_reg.part_reset;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_gate_follow;
    1'b1 |=> periph_clk_en == active_gates(state_reg);
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("Clock enable off set"); // RULE_01

  property p_bus_fault;
    periph_access.timer0_gate && !periph_clk_en.timer0_gate |-> periph_bus_fault.timer0_gate;
  endproperty
  a_bus_fault: assert property (p_bus_fault) else $error("Missing bus fault"); // RULE_02

  property p_reserved;
    (state_reg.run1 & ~clk_gate_pkg::SET1_MASK) == 32'h0000_0000 &&
      (state_reg.dsl2 & ~clk_gate_pkg::SET2_MASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set"); // RULE_09

  property p_sleep_no_acg;
    power_state == clk_gate_pkg::PWR_SLEEP && !state_reg.auto_gating_select &&
      $stable(state_reg) |=> periph_clk_en == map_gates(state_reg.run1, state_reg.run2);
  endproperty
  a_sleep_no_acg: assert property (p_sleep_no_acg) else $error("Sleep set without auto"); // RULE_05

  property p_deep_internal_osc_select;
    power_state == clk_gate_pkg::PWR_RUN && deep_sleep_req && state_reg.internal_osc_select
      |=> sysclk_internal_sel && main_osc_pwrdn && internal_osc_pwrup;
  endproperty
  a_deep_internal_osc_select: assert property (p_deep_internal_osc_select) else $error("Internal osc not chosen"); // RULE_10

  property p_deep_main;
    power_state == clk_gate_pkg::PWR_RUN && deep_sleep_req && !state_reg.internal_osc_select
      |=> !main_osc_pwrdn && sysclk_internal_sel == $past(sysclk_internal_sel);
  endproperty
  a_deep_main: assert property (p_deep_main) else $error("Main osc dropped"); // RULE_11

  property p_restore;
    power_state == clk_gate_pkg::PWR_DEEP && wake_event
      |=> power_state == clk_gate_pkg::PWR_RUN && sysclk_internal_sel == $past(state_reg.saved_sel);
  endproperty
  a_restore: assert property (p_restore) else $error("Clock not restored"); // RULE_12

  property p_fault_sub;
    $rose(state_reg.fault_level) |-> backup_clk_sel;
  endproperty
  a_fault_sub: assert property (p_fault_sub) else $error("No backup clock"); // RULE_13

  property p_fault_clear;
    state_reg.verify_fault_clear_bit && !state_reg.fault_level ##1 !$rose(state_reg.fault_level)
      |-> !backup_clk_sel;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("Fault not cleared"); // RULE_14

  property p_ldo;
    !state_reg.regulator_fault_reset_enable |=> !part_reset_req;
  endproperty
  a_ldo: assert property (p_ldo) else $error("Reset while disabled"); // RULE_15

  // With auto gating on, the sleep set drives the enables in that same cycle.
  property p_sleep_acg;
    power_state == clk_gate_pkg::PWR_SLEEP && state_reg.auto_gating_select
      |-> periph_clk_en == map_gates(state_reg.slp1, state_reg.slp2);
  endproperty
  a_sleep_acg: assert property (p_sleep_acg) else $error("Sleep set not applied"); // RULE_05

  // Only a wake event takes the block out of sleep; other requests are ignored.
  property p_stay_sleep;
    power_state == clk_gate_pkg::PWR_SLEEP && !wake_event |=> power_state == clk_gate_pkg::PWR_SLEEP;
  endproperty
  a_stay_sleep: assert property (p_stay_sleep) else $error("Sleep left without wake"); // RULE_16

  c_deep_wake: cover property (power_state == clk_gate_pkg::PWR_DEEP ##[1:20]
    power_state == clk_gate_pkg::PWR_RUN);
  c_sleep_set: cover property (power_state == clk_gate_pkg::PWR_SLEEP &&
    state_reg.auto_gating_select && periph_clk_en != '0);
  c_bus_fault: cover property (periph_bus_fault != '0);
  c_part_reset: cover property (part_reset_req);

endmodule
`default_nettype wire

// ===== clk_gate_pkg.sv
/*
 * Constants and types of the peripheral clock gating control block:
 * register offsets, field positions, writable-bit masks, reset values,
 * power states and the packed gate vector.
 * Assumes a 32-bit AHB-Lite register bus decoded on the low 12 address bits.
 */
`default_nettype none
package clk_gate_pkg;

  // ****************************************************************
  // Register offsets (byte addresses within the block).
  // ****************************************************************
  localparam logic [11:0] RUN_GATING_SET1_OFS = 12'h104;
  localparam logic [11:0] RUN_GATING_SET2_OFS = 12'h108;
  localparam logic [11:0] SLEEP_GATING_SET1_OFS = 12'h114;
  localparam logic [11:0] SLEEP_GATING_SET2_OFS = 12'h118;
  localparam logic [11:0] DEEP_SLEEP_GATING_SET1_OFS = 12'h124;
  localparam logic [11:0] DEEP_SLEEP_GATING_SET2_OFS = 12'h128;
  localparam logic [11:0] DEEP_SLEEP_CLOCK_SELECT_OFS = 12'h144;
  localparam logic [11:0] CLOCK_CHECK_FAULT_CLEAR_OFS = 12'h150;
  localparam logic [11:0] REGULATOR_FAULT_RESET_CTL_OFS = 12'h160;
  localparam logic [11:0] GATING_MODE_CTL_OFS = 12'h170;

  // ****************************************************************
  // Field positions and writable masks.
  // ****************************************************************
  localparam int COMPARATOR0_BIT = 24;
  localparam int TIMER2_BIT = 18;
  localparam int TIMER1_BIT = 17;
  localparam int TIMER0_BIT = 16;
  localparam int I2C_BIT = 12;
  localparam int SYNC_SERIAL_BIT = 4;
  localparam int ASYNC_SERIAL1_BIT = 1;
  localparam int ASYNC_SERIAL0_BIT = 0;
  localparam int GPIO_LAST_BIT = 4;
  localparam int CTRL_BIT = 0;
  localparam logic [31:0] SET1_MASK = 32'h0107_1013;
  localparam logic [31:0] SET2_MASK = 32'h0000_001f;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [31:0] GATING_RESET = 32'h0000_0000;
  localparam logic CTRL_RESET = 1'b0;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_DEEP = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic comparator0_gate;
    logic timer2_gate;
    logic timer1_gate;
    logic timer0_gate;
    logic i2c_gate;
    logic sync_serial_gate;
    logic async_serial1_gate;
    logic async_serial0_gate;
    logic [GPIO_LAST_BIT:0] gpio_gate;
  } gate_vec_t;

endpackage
`default_nettype wire

// ===== tb_peripheral_clock_gating_control.sv
/*
 * Self-checking testbench of the peripheral clock gating control block:
 * register reset and read-back, gate mapping, bus faults, power-state set
 * choice, deep-sleep oscillator handling, clock-check fault and regulator reset.
 * Assumes the clk_gate_pkg package and the clk_gate_ctrl module are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_clock_gating_control;

  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic clk, rstn, hsel, hwrite, sleep_req, deep_sleep_req, wake_event;
  logic [31:0] haddr, hwdata, hrdata, seed, rd, r1, r2, s1, s2, d1, d2;
  logic [1:0] htrans, power_state;
  logic [2:0] hsize;
  logic hreadyout, hresp, sysclk_internal_sel, main_osc_pwrdn, internal_osc_pwrup;
  logic clk_check_fault, backup_clk_sel, regulator_unregulated, part_reset_req;
  clk_gate_pkg::gate_vec_t periph_access, periph_clk_en, periph_bus_fault;
  int n_fail, compares;
  wire logic hready_w;
  logic [11:0] addr_t [9] = '{12'h104, 12'h108, 12'h114, 12'h118, 12'h124, 12'h128,
                              12'h144, 12'h150, 12'h160};
  logic [31:0] mask_t [9] = '{32'h0107_1013, 32'h0000_001f, 32'h0107_1013, 32'h0000_001f,
                              32'h0107_1013, 32'h0000_001f, 32'h0000_0001, 32'h0000_0001,
                              32'h0000_0001};

  // The single slave's ready is the bus ready.
  assign hready_w = hreadyout;

  clk_gate_ctrl DUT (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_w),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .wake_event(wake_event),
    .periph_access(periph_access), .periph_clk_en(periph_clk_en),
    .periph_bus_fault(periph_bus_fault), .power_state(power_state),
    .sysclk_internal_sel(sysclk_internal_sel), .main_osc_pwrdn(main_osc_pwrdn),
    .internal_osc_pwrup(internal_osc_pwrup), .clk_check_fault(clk_check_fault),
    .backup_clk_sel(backup_clk_sel), .regulator_unregulated(regulator_unregulated),
    .part_reset_req(part_reset_req)
  );

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Makes the 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Steps the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected gate vector from the two words of one gating set.
  function automatic clk_gate_pkg::gate_vec_t gv(input logic [31:0] a, input logic [31:0] b);
    return {a[24], a[18], a[17], a[16], a[12], a[4], a[1], a[0], b[4:0]};
  endfunction

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits n edges and lets their updates settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One single AHB-Lite word transfer; read data taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge clk);
    while (hready_w !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready_w !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Pulses the power requests for one cycle and lets the state move.
  task automatic pwr(input logic s, input logic d, input logic w);
    @(posedge clk);
    sleep_req <= s;
    deep_sleep_req <= d;
    wake_event <= w;
    @(posedge clk);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    wake_event <= 1'b0;
    cyc(3);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  // Works through reset, registers, gating, power states and faults.
  initial begin
    {rstn, hsel, hwrite, sleep_req, deep_sleep_req, wake_event} = '0;
    {haddr, hwdata, htrans, clk_check_fault, regulator_unregulated} = '0;
    hsize = 3'b010;
    periph_access = '0;
    n_fail = 0;
    compares = 0;
    seed = 32'h177e_6b5d;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) rchk(addr_t[i], 32'h0000_0000);
    chk(32'(periph_clk_en), 32'h0000_0000);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      bus(1'b1, addr_t[i], seed);
      rchk(addr_t[i], seed & mask_t[i]);
    end
    bus(1'b1, 12'h200, 32'hffff_ffff);
    rchk(12'h200, 32'h0000_0000);
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    for (int i = 6; i < 9; i++) bus(1'b1, addr_t[i], 32'h0000_0000);
    $display("test register read-back done");
    for (int k = 0; k < 6; k++) begin
      r1 = (k == 0) ? 32'hffff_ffff : lfsr(seed);
      r2 = (k == 0) ? 32'hffff_ffff : lfsr(r1);
      seed = lfsr(r2);
      bus(1'b1, 12'h104, r1);
      bus(1'b1, 12'h108, r2);
      cyc(2);
      chk(32'(periph_clk_en), 32'(gv(r1, r2)));
      @(posedge clk);
      periph_access <= seed[12:0];
      cyc(1);
      chk(32'(periph_bus_fault), 32'(seed[12:0] & ~gv(r1, r2)));
    end
    $display("test gate mapping done");
    s1 = lfsr(seed);
    s2 = lfsr(s1);
    d1 = lfsr(s2);
    d2 = lfsr(d1);
    seed = d2;
    bus(1'b1, 12'h114, s1);
    bus(1'b1, 12'h118, s2);
    bus(1'b1, 12'h124, d1);
    bus(1'b1, 12'h128, d2);
    pwr(1'b1, 1'b0, 1'b0);
    chk(32'(power_state), 32'h0000_0001);
    chk(32'(periph_clk_en), 32'(gv(r1, r2)));
    pwr(1'b0, 1'b0, 1'b1);
    bus(1'b1, clk_gate_pkg::GATING_MODE_CTL_OFS, 32'h0000_0001);
    pwr(1'b1, 1'b0, 1'b0);
    chk(32'(periph_clk_en), 32'(gv(s1, s2)));
    pwr(1'b0, 1'b1, 1'b0);
    chk(32'(power_state), 32'h0000_0001);
    pwr(1'b0, 1'b0, 1'b1);
    chk(32'(periph_clk_en), 32'(gv(r1, r2)));
    pwr(1'b1, 1'b1, 1'b0);
    chk(32'(power_state), 32'h0000_0003);
    chk(32'(periph_clk_en), 32'(gv(d1, d2)));
    pwr(1'b0, 1'b0, 1'b1);
    chk(32'(power_state), 32'h0000_0000);
    $display("test power states done");
    pwr(1'b0, 1'b1, 1'b0);
    chk({30'h0, sysclk_internal_sel, main_osc_pwrdn}, 32'h0000_0000);
    pwr(1'b0, 1'b0, 1'b1);
    bus(1'b1, 12'h144, 32'h0000_0001);
    pwr(1'b0, 1'b1, 1'b0);
    chk({29'h0, sysclk_internal_sel, main_osc_pwrdn, internal_osc_pwrup}, 32'h0000_0007);
    pwr(1'b0, 1'b0, 1'b1);
    chk({29'h0, sysclk_internal_sel, main_osc_pwrdn, internal_osc_pwrup}, 32'h0000_0000);
    $display("test deep-sleep oscillator done");
    @(posedge clk);
    clk_check_fault <= 1'b1;
    cyc(8);
    chk(32'(backup_clk_sel), 32'h0000_0001);
    rchk(clk_gate_pkg::GATING_MODE_CTL_OFS, 32'h0000_0003);
    @(posedge clk);
    clk_check_fault <= 1'b0;
    cyc(8);
    chk(32'(backup_clk_sel), 32'h0000_0001);
    bus(1'b1, 12'h150, 32'h0000_0001);
    cyc(2);
    chk(32'(backup_clk_sel), 32'h0000_0000);
    rchk(12'h150, 32'h0000_0001);
    bus(1'b1, 12'h150, 32'h0000_0000);
    $display("test clock-check fault done");
    @(posedge clk);
    regulator_unregulated <= 1'b1;
    cyc(10);
    chk(32'(part_reset_req), 32'h0000_0000);
    bus(1'b1, 12'h160, 32'h0000_0001);
    cyc(10);
    chk(32'(part_reset_req), 32'h0000_0001);
    @(posedge clk);
    regulator_unregulated <= 1'b0;
    rstn <= 1'b0;
    cyc(5);
    @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    chk(32'(periph_clk_en), 32'h0000_0000);
    chk(32'(part_reset_req), 32'h0000_0000);
    rchk(12'h104, 32'h0000_0000);
    $display("test regulator reset and second reset done");
    test_done;
  end

endmodule
`default_nettype wire
